//--- src/ubd_pkg.sv
// constants and types shared by the buffer descriptor engine and its testbench
// Contract
// RULE_01: descriptor is four bytes, 32 descriptors
// RULE_02: table starts at 200h, status first
// RULE_03: table spans 8 to 128 bytes
// RULE_04: disabled endpoint descriptors are plain RAM
// RULE_05: descriptor contents never initialised by reset
// RULE_06: software fills descriptor before enabling endpoint
// RULE_07: bit 7 set means engine owns
// RULE_08: core leaves engine-owned descriptors alone
// RULE_09: status byte readable by both sides always
// RULE_10: engine writes token pid and count
// RULE_11: software writes status byte last
// RULE_12: engine clears ownership when transaction completes
// RULE_13: bit 3 enables toggle check against bit 6
// RULE_14: mismatched OUT acked, dropped, nothing updated
// RULE_15: good OUT acked, released, flagged, updated
// RULE_16: SETUP accepted despite toggle mismatch
// RULE_17: bit 2 stalls token, flags, keeps descriptor
// RULE_18: SETUP on stalled descriptor clears and releases
// RULE_19: ten bit count, high bits in status
// RULE_20: software keeps status bits 5-4 zero
// RULE_21: software sets ownership before module enable
// RULE_22: write back actual count, oversize gets NAK
// RULE_23: engine layout: pid in 5-2, 6 untouched
// RULE_24: shared RAM arbitrates core before engine
package ubd_pkg;
	localparam int          RAM_BYTES   = 256;
	localparam logic [11:0] RAM_BASE    = 12'h200;
	localparam logic [15:0] RAM_BASE16  = 16'h0200;
	localparam int          DESC_COUNT  = 32;
	localparam logic [1:0]  OFF_STAT    = 2'h0;
	localparam logic [1:0]  OFF_CNT     = 2'h1;
	localparam logic [1:0]  OFF_ADRL    = 2'h2;
	localparam logic [1:0]  OFF_ADRH    = 2'h3;
	localparam int          OWN_BIT     = 7;
	localparam int          TOG_BIT     = 6;
	localparam int          CHK_BIT     = 3;
	localparam int          STALL_BIT   = 2;
	localparam logic [3:0]  PID_OUT     = 4'h1;
	localparam logic [3:0]  PID_IN      = 4'h9;
	localparam logic [3:0]  PID_SETUP   = 4'hD;
	localparam logic [1:0]  HS_ACK      = 2'h0;
	localparam logic [1:0]  HS_NAK      = 2'h1;
	localparam logic [1:0]  HS_STALL    = 2'h2;
	localparam int          FW_LAST     = 8;
	localparam int          FW_ERR      = 9;
	localparam int          FW_NODATA   = 10;
	localparam int          FW_WIDTH    = 11;
	localparam int          FIFO_DEPTH  = 32;
	typedef enum logic [3:0] {
		S_IDLE, S_RSTAT, S_RCNT, S_RADL, S_RADH, S_IN, S_OUT, S_WCNT, S_WSTAT, S_DRAIN, S_RESP
	} ubd_state_t;
endpackage : ubd_pkg

//--- src/ubd_stream_if.sv
// valid/ready stream carrier between the engine and its receive fifo
`timescale 1ns/1ps
`default_nettype none
interface ubd_stream_if #(parameter int WIDTH = 11);
	logic             wr_valid;
	logic             wr_ready;
	logic [WIDTH-1:0] wr_data;
	logic             rd_valid;
	logic             rd_ready;
	logic [WIDTH-1:0] rd_data;
	modport fifo (input wr_valid, input wr_data, input rd_ready, output wr_ready, output rd_valid, output rd_data);
	modport user (output wr_valid, output wr_data, output rd_ready, input wr_ready, input rd_valid, input rd_data);
endinterface : ubd_stream_if
`default_nettype wire

//--- src/ubd_fifo.sv
// receive fifo with registered full and empty flags
`timescale 1ns/1ps
`default_nettype none
module ubd_fifo #(
	parameter int WIDTH = 11,
	parameter int DEPTH = 32
) (
	input wire logic   clk_in,   // core clock
	input wire logic   reset_in, // synchronous reset
	ubd_stream_if.fifo port      // write and read sides
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [AW-1:0] wr_ptr;
		logic [AW-1:0] rd_ptr;
		logic [AW:0]   count;
		logic          wr_ready;
		logic          rd_valid;
	} ubd_fifo_state_t;
	ubd_fifo_state_t  st;
	ubd_fifo_state_t  next_st;
	logic [WIDTH-1:0] mem [DEPTH];
	logic             push;
	logic             pop;

	assign push         = port.wr_valid && st.wr_ready;
	assign pop          = port.rd_ready && st.rd_valid;
	assign port.wr_ready = st.wr_ready;
	assign port.rd_valid = st.rd_valid;
	assign port.rd_data  = mem[st.rd_ptr];

	always_comb begin
		next_st = st;
		if (push) begin
			next_st.wr_ptr = AW'((int'(st.wr_ptr) + 1) % DEPTH);
		end
		if (pop) begin
			next_st.rd_ptr = AW'((int'(st.rd_ptr) + 1) % DEPTH);
		end
		next_st.count    = (AW+1)'(int'(st.count) + int'(push) - int'(pop));
		next_st.wr_ready = int'(next_st.count) < DEPTH;
		next_st.rd_valid = next_st.count != '0;
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			st          <= '0;
			st.wr_ready <= 1'h1;
		end else begin
			st <= next_st;
		end
	end

	always_ff @(posedge clk_in) begin
		if (push) begin
			mem[st.wr_ptr] <= port.wr_data;
		end
	end
endmodule : ubd_fifo
`default_nettype wire

//--- src/ubd_table.sv
// shared USB RAM with buffer descriptor engine serving host tokens
`timescale 1ns/1ps
`default_nettype none
module ubd_table (
	input  wire logic               clk_in,            // core clock
	input  wire logic               reset_in,          // synchronous reset
	input  wire logic [11:0]        core_addr_in,      // core data address
	input  wire logic               core_we_in,        // core write strobe
	input  wire logic               core_re_in,        // core read strobe
	input  wire logic [7:0]         core_wdata_in,     // core write data
	output var  logic [7:0]         core_rdata_out,    // core read data, next cycle
	input  wire logic               token_valid_in,    // token offered
	input  wire logic [3:0]         token_pid_in,      // token pid
	input  wire logic [4:0]         token_desc_in,     // descriptor used by token
	input  wire logic               token_ep_en_in,    // endpoint enable, checked for IN, OUT and SETUP tokens alike
	input  wire logic               token_toggle_in,   // data toggle of following packet
	output var  logic               token_ready_out,   // engine idle
	input  wire logic               rx_valid_in,       // receive word offered
	input  wire logic [7:0]         rx_data_in,        // receive byte
	input  wire logic               rx_last_in,        // last word of packet
	input  wire logic               rx_err_in,         // packet error, with last
	input  wire logic               rx_nodata_in,      // word carries no byte
	output var  logic               rx_ready_out,      // fifo has room
	output var  logic               tx_valid_out,      // transmit byte valid
	output var  logic [7:0]         tx_data_out,       // transmit byte
	output var  logic               tx_last_out,       // last transmit word
	output var  logic               tx_nodata_out,     // zero length packet marker
	input  wire logic               tx_ready_in,       // transmit sink ready
	output var  logic               hs_valid_out,      // handshake pulse
	output var  logic [1:0]         hs_code_out,       // handshake code
	output var  logic               stall_flag_out,    // set endpoint_stall_flag pulse
	output var  logic               stall_irq_out,     // stall interrupt pulse
	output var  logic               trn_done_out,      // transfer_complete_flag pulse
	output var  logic [7:0]         trn_status_out     // transaction_status
);
	import ubd_pkg::*;

	typedef struct packed {
		ubd_state_t  state;
		logic [3:0]  pid;
		logic [4:0]  desc;
		logic        tog;
		logic        quiet;
		logic        mis;
		logic        ovf;
		logic        err;
		logic [7:0]  stat;
		logic [9:0]  cnt;
		logic [7:0]  addr;
		logic [9:0]  idx;
		logic [1:0]  code;
		logic        hs_valid;
		logic [1:0]  hs_code;
		logic        stall_flag;
		logic        stall_irq;
		logic        trn_done;
		logic [7:0]  trn_status;
		logic        tx_valid;
		logic [7:0]  tx_data;
		logic        tx_last;
		logic        tx_nodata;
		logic [7:0]  core_rdata;
		logic        token_ready;
	} ubd_top_state_t;

	ubd_top_state_t st;
	ubd_top_state_t next_st;
	// descriptor contents stay as they are across reset
	logic [7:0]     ram [RAM_BYTES];
	logic           in_window;
	logic           core_req;
	logic           grant;
	logic [7:0]     core_off;
	logic [7:0]     eng_addr;
	logic           eng_we;
	logic [7:0]     eng_wdata;
	logic [7:0]     eng_rd;
	logic [15:0]    buf_abs;
	logic [FW_WIDTH-1:0] word;

	ubd_stream_if #(.WIDTH(FW_WIDTH)) rx_if ();

	ubd_fifo #(
		.WIDTH (FW_WIDTH),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk_in   (clk_in),
		.reset_in (reset_in),
		.port     (rx_if.fifo)
	);

	assign rx_if.wr_valid = rx_valid_in;
	assign rx_if.wr_data  = {rx_nodata_in, rx_err_in, rx_last_in, rx_data_in};
	assign rx_ready_out   = rx_if.wr_ready;
	assign word           = rx_if.rd_data;

	// RULE_02: table in window
	assign in_window = core_addr_in[11:8] == RAM_BASE[11:8];
	assign core_off  = core_addr_in[7:0];
	// RULE_24: core first
	assign core_req  = (core_we_in || core_re_in) && in_window;
	assign grant     = !core_req;
	assign eng_rd    = ram[eng_addr];
	assign buf_abs   = {eng_rd, st.addr} - RAM_BASE16;

	always_comb begin
		next_st            = st;
		next_st.hs_valid   = 1'h0;
		next_st.stall_flag = 1'h0;
		next_st.stall_irq  = 1'h0;
		next_st.trn_done   = 1'h0;
		// RULE_01: four-byte descriptor blocks
		// RULE_03: table within low 128
		eng_addr           = {1'h0, st.desc, OFF_STAT};
		eng_we             = 1'h0;
		eng_wdata          = 8'h00;
		rx_if.rd_ready     = 1'h0;
		// RULE_09: status always readable
		if (core_re_in) begin
			next_st.core_rdata = in_window ? ram[core_off] : 8'h00;
		end
		if (st.tx_valid && tx_ready_in) begin
			next_st.tx_valid = 1'h0;
		end
		case (st.state)
			S_IDLE: begin
				if (token_valid_in && st.token_ready) begin
					next_st.pid   = token_pid_in;
					next_st.desc  = token_desc_in;
					next_st.tog   = token_toggle_in;
					next_st.quiet = 1'h0;
					next_st.mis   = 1'h0;
					next_st.ovf   = 1'h0;
					next_st.err   = 1'h0;
					next_st.state = S_RSTAT;
					// RULE_04: disabled endpoint ignored
					if (!token_ep_en_in) begin
						next_st.quiet = 1'h1;
						next_st.state = (token_pid_in == PID_IN) ? S_IDLE : S_DRAIN;
					end
				end
			end
			S_RSTAT: begin
				if (grant) begin
					next_st.stat = eng_rd;
					next_st.cnt  = {eng_rd[1:0], st.cnt[7:0]};
					next_st.state = (st.pid == PID_IN) ? S_RESP : S_DRAIN;
					// RULE_07: only engine-owned descriptors served
					if (!eng_rd[OWN_BIT]) begin
						next_st.code = HS_NAK;
					end else if (eng_rd[STALL_BIT]) begin
						if (st.pid == PID_SETUP) begin
							// RULE_18: setup unstalls, releases
							eng_we       = 1'h1;
							eng_wdata            = eng_rd;
							eng_wdata[OWN_BIT]   = 1'h0;
							eng_wdata[STALL_BIT] = 1'h0;
							next_st.code = HS_ACK;
						end else begin
							// RULE_17: stall, descriptor kept
							next_st.code = HS_STALL;
						end
					end else begin
						// RULE_13: toggle compare
						next_st.mis   = eng_rd[CHK_BIT] && (st.pid == PID_OUT) && (st.tog != eng_rd[TOG_BIT]);
						next_st.state = S_RCNT;
					end
				end
			end
			S_RCNT: begin
				eng_addr = {1'h0, st.desc, OFF_CNT};
				if (grant) begin
					// RULE_19: ten bit count
					next_st.cnt   = {st.cnt[9:8], eng_rd};
					next_st.state = S_RADL;
				end
			end
			S_RADL: begin
				eng_addr = {1'h0, st.desc, OFF_ADRL};
				if (grant) begin
					next_st.addr  = eng_rd;
					next_st.state = S_RADH;
				end
			end
			S_RADH: begin
				eng_addr = {1'h0, st.desc, OFF_ADRH};
				if (grant) begin
					next_st.addr  = buf_abs[7:0];
					next_st.idx   = 10'h000;
					next_st.ovf   = 1'h0;
					next_st.err   = 1'h0;
					next_st.quiet = st.pid == PID_IN;
					next_st.state = (st.pid == PID_IN) ? S_IN : S_OUT;
				end
			end
			S_IN: begin
				eng_addr = st.addr + st.idx[7:0];
				if (grant && (!st.tx_valid || tx_ready_in)) begin
					next_st.tx_valid  = 1'h1;
					next_st.tx_data   = (st.cnt == 10'h000) ? 8'h00 : eng_rd;
					next_st.tx_nodata = st.cnt == 10'h000;
					next_st.tx_last   = (st.cnt == 10'h000) || (st.idx + 10'h001 == st.cnt);
					if (st.cnt != 10'h000) begin
						next_st.idx = st.idx + 10'h001;
					end
					if (next_st.tx_last) begin
						next_st.state = S_WCNT;
					end
				end
			end
			S_OUT: begin
				eng_addr = st.addr + st.idx[7:0];
				if (grant && rx_if.rd_valid) begin
					rx_if.rd_ready = 1'h1;
					if (!word[FW_NODATA]) begin
						if (st.idx < st.cnt) begin
							// RULE_14: mismatched data not stored
							eng_we      = !st.mis;
							eng_wdata   = word[7:0];
							next_st.idx = st.idx + 10'h001;
						end else begin
							next_st.ovf = 1'h1;
						end
					end
					if (word[FW_LAST]) begin
						next_st.err   = word[FW_ERR];
						next_st.code  = (word[FW_ERR] || next_st.ovf) ? HS_NAK : HS_ACK;
						// RULE_22: oversize or error, no update
						// RULE_16: setup never marked mismatched
						next_st.state = (word[FW_ERR] || next_st.ovf || st.mis) ? S_RESP : S_WCNT;
					end
				end
			end
			S_WCNT: begin
				eng_addr = {1'h0, st.desc, OFF_CNT};
				if (grant) begin
					// RULE_10: engine writes count
					// RULE_22: actual count back
					eng_we        = 1'h1;
					eng_wdata     = st.idx[7:0];
					next_st.state = S_WSTAT;
				end
			end
			S_WSTAT: begin
				if (grant) begin
					// RULE_12: release; RULE_23: pid in, bit 6 kept
					eng_we             = 1'h1;
					eng_wdata          = {1'h0, st.stat[TOG_BIT], st.pid, st.idx[9:8]};
					// RULE_15: flag and status on completion
					next_st.trn_done   = 1'h1;
					next_st.trn_status = {st.desc, st.pid == PID_IN, 2'h0};
					next_st.code       = HS_ACK;
					next_st.state      = S_RESP;
				end
			end
			S_DRAIN: begin
				rx_if.rd_ready = 1'h1;
				if (rx_if.rd_valid && word[FW_LAST]) begin
					next_st.state = S_RESP;
				end
			end
			S_RESP: begin
				if (!st.quiet) begin
					next_st.hs_valid   = 1'h1;
					next_st.hs_code    = st.code;
					next_st.stall_flag = st.code == HS_STALL;
					next_st.stall_irq  = st.code == HS_STALL;
				end
				next_st.state = S_IDLE;
			end
			default: begin
				next_st.state = S_IDLE;
			end
		endcase
		next_st.token_ready = next_st.state == S_IDLE;
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			st             <= '0;
			st.state       <= S_IDLE;
			st.token_ready <= 1'h1;
		end else begin
			st <= next_st;
		end
	end

	// RULE_05: no reset on RAM; RULE_24: core write wins
	always_ff @(posedge clk_in) begin
		if (core_we_in && in_window) begin
			ram[core_off] <= core_wdata_in;
		end else if (eng_we) begin
			ram[eng_addr] <= eng_wdata;
		end
	end

	assign core_rdata_out  = st.core_rdata;
	assign token_ready_out = st.token_ready;
	assign tx_valid_out    = st.tx_valid;
	assign tx_data_out     = st.tx_data;
	assign tx_last_out     = st.tx_last;
	assign tx_nodata_out   = st.tx_nodata;
	assign hs_valid_out    = st.hs_valid;
	assign hs_code_out     = st.hs_code;
	assign stall_flag_out  = st.stall_flag;
	assign stall_irq_out   = st.stall_irq;
	assign trn_done_out    = st.trn_done;
	assign trn_status_out  = st.trn_status;

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (reset_in);

	sequence wstat_write;
		st.state == S_WSTAT && eng_we;
	endsequence
	sequence resp_step;
		st.state == S_RESP && !st.quiet;
	endsequence

	stall_flags_a: assert property (hs_valid_out && hs_code_out == HS_STALL |-> stall_flag_out && stall_irq_out) // RULE_17
		else $error("stall handshake without stall flag and interrupt");
	stall_keep_a: assert property (st.state == S_RSTAT && grant && eng_rd[OWN_BIT] && eng_rd[STALL_BIT] && st.pid != PID_SETUP |-> !eng_we) // RULE_17
		else $error("stalled descriptor was modified");
	release_own_a: assert property (wstat_write |-> eng_wdata[OWN_BIT] == 1'h0 ##1 trn_done_out) // RULE_12
		else $error("completion did not release ownership");
	keep_tog_a: assert property (wstat_write |-> eng_wdata[TOG_BIT] == st.stat[TOG_BIT] && eng_wdata[5:2] == st.pid) // RULE_23
		else $error("status writeback wrong pid or bit 6");
	drop_bad_a: assert property (st.state == S_OUT && st.mis |-> !eng_we) // RULE_14
		else $error("mismatched packet written to RAM");
	mis_none_a: assert property (st.state == S_RCNT && st.pid == PID_SETUP |-> !st.mis) // RULE_16
		else $error("setup flagged as toggle mismatch");
	ovf_nak_a: assert property (st.state == S_RESP && st.ovf && !st.quiet |=> hs_valid_out && hs_code_out == HS_NAK) // RULE_22
		else $error("oversize packet not refused with NAK");
	quiet_a: assert property (st.state == S_IDLE && st.token_ready && token_valid_in && !token_ep_en_in
		|=> (!hs_valid_out && !trn_done_out)[*3]) // RULE_04
		else $error("disabled endpoint answered");
	core_first_a: assert property (core_req |-> !eng_we) // RULE_24
		else $error("engine wrote during core access");
	resp_hs_a: assert property (resp_step ##1 1'h1 |-> hs_valid_out && hs_code_out == $past(st.code)) // RULE_15
		else $error("response handshake missing");
	setup_rel_a: assert property (st.state == S_RSTAT && grant && eng_rd[OWN_BIT] && eng_rd[STALL_BIT]
		&& st.pid == PID_SETUP |-> eng_we && !eng_wdata[OWN_BIT] && !eng_wdata[STALL_BIT]) // RULE_18
		else $error("setup did not clear stall");
endmodule : ubd_table
`default_nettype wire

//--- dv/ubd_host_model.sv
// host side model: offers tokens, feeds receive words, sinks transmit bytes
`timescale 1ns/1ps
`default_nettype none
module ubd_host_model (
	input  wire logic       clk_in,    // core clock
	output var  logic       tv_out,    // token valid
	output var  logic [3:0] tpid_out,  // token pid
	output var  logic [4:0] tdesc_out, // descriptor number
	output var  logic       ten_out,   // endpoint enable
	output var  logic       ttog_out,  // data toggle
	input  wire logic       trdy_in,   // engine idle
	output var  logic       rv_out,    // receive word valid
	output var  logic [7:0] rdata_out, // receive byte
	output var  logic       rlast_out, // last word
	output var  logic       rerr_out,  // packet error
	input  wire logic       rrdy_in,   // fifo room
	input  wire logic       txv_in,    // transmit valid
	input  wire logic [7:0] txd_in,    // transmit byte
	output var  logic       txr_out    // sink ready
);
	import ubd_pkg::*;
	logic       slow = 1'b0;
	logic [7:0] got_q[$];
	initial begin
		tv_out = 1'b0;
		tpid_out = 4'h0;
		tdesc_out = 5'h00;
		ten_out = 1'b0;
		ttog_out = 1'b0;
		rv_out = 1'b0;
		rdata_out = 8'h00;
		rlast_out = 1'b0;
		rerr_out = 1'b0;
		txr_out = 1'b1;
	end
	// slow sink holds off every other cycle
	always @(posedge clk_in) txr_out <= #1 slow ? ~txr_out : 1'b1;
	always @(negedge clk_in) if (txv_in && txr_out) got_q.push_back(txd_in);
	task automatic token(input logic [3:0] pid, input logic [4:0] d, input logic en, input logic tog);
		@(posedge clk_in);
		#1;
		tpid_out = pid;
		tdesc_out = d;
		ten_out = en;
		ttog_out = tog;
		tv_out = 1'b1;
		while (trdy_in !== 1'b1) begin
			@(posedge clk_in);
			#1;
		end
		@(posedge clk_in);
		#1;
		tv_out = 1'b0;
		// released fields stop showing the old token
		tpid_out = ~tpid_out;
		tdesc_out = ~tdesc_out;
	endtask : token
	task automatic word(input logic [7:0] b, input logic last, input logic err);
		@(posedge clk_in);
		#1;
		rdata_out = b;
		rlast_out = last;
		rerr_out = err;
		rv_out = 1'b1;
		while (rrdy_in !== 1'b1) begin
			@(posedge clk_in);
			#1;
		end
		@(posedge clk_in);
		#1;
		rv_out = 1'b0;
		rdata_out = ~rdata_out;
	endtask : word
	task automatic packet(input int n, input logic [7:0] b0);
		for (int i = 0; i < n; i++) word(b0 + 8'(i), i == n - 1, 1'b0);
	endtask : packet
endmodule : ubd_host_model
`default_nettype wire

//--- dv/ubd_table_tb_top.sv
// testbench for the buffer descriptor engine
`timescale 1ns/1ps
`default_nettype none
module ubd_table_tb_top;
	import ubd_pkg::*;
	logic        clk_in, reset_in, core_we_in, core_re_in;
	logic [11:0] core_addr_in;
	logic [7:0]  core_wdata_in, core_rdata_out, rx_data_in, tx_data_out, trn_status_out, rdv;
	logic        token_valid_in, token_ep_en_in, token_toggle_in, token_ready_out;
	logic [3:0]  token_pid_in;
	logic [4:0]  token_desc_in;
	logic        rx_valid_in, rx_last_in, rx_err_in, rx_ready_out, tx_valid_out, tx_ready_in;
	logic        hs_valid_out, stall_flag_out, stall_irq_out, trn_done_out, tx_last_out, tx_nodata_out;
	logic [1:0]  hs_code_out, hs_last;
	logic        rx_nodata_in = 1'b0;
	int          fails = 0;
	int          check_count = 0;
	int          hs_n, done_n, stall_n, last_n, nd_n;
	ubd_table i_dut (
		.clk_in, .reset_in, .core_addr_in, .core_we_in, .core_re_in, .core_wdata_in, .core_rdata_out,
		.token_valid_in, .token_pid_in, .token_desc_in, .token_ep_en_in, .token_toggle_in, .token_ready_out,
		.rx_valid_in, .rx_data_in, .rx_last_in, .rx_err_in, .rx_nodata_in, .rx_ready_out,
		.tx_valid_out, .tx_data_out, .tx_last_out, .tx_nodata_out, .tx_ready_in,
		.hs_valid_out, .hs_code_out, .stall_flag_out, .stall_irq_out, .trn_done_out, .trn_status_out
	);
	ubd_host_model i_host (
		.clk_in,
		.tv_out(token_valid_in), .tpid_out(token_pid_in), .tdesc_out(token_desc_in), .ten_out(token_ep_en_in),
		.ttog_out(token_toggle_in), .trdy_in(token_ready_out), .rv_out(rx_valid_in), .rdata_out(rx_data_in),
		.rlast_out(rx_last_in), .rerr_out(rx_err_in), .rrdy_in(rx_ready_out), .txv_in(tx_valid_out),
		.txd_in(tx_data_out), .txr_out(tx_ready_in)
	);
	initial begin
		clk_in = 1'b0;
		forever #2 clk_in = ~clk_in;
	end
	// event pulses counted where they are settled
	always @(negedge clk_in) begin
		if (hs_valid_out === 1'b1) begin
			hs_n++;
			hs_last = hs_code_out;
		end
		if (trn_done_out === 1'b1) done_n++;
		if (stall_flag_out === 1'b1 && stall_irq_out === 1'b1 && hs_valid_out === 1'b1) stall_n++;
		if (tx_valid_out === 1'b1 && tx_ready_in === 1'b1 && tx_last_out === 1'b1) last_n++;
		if (tx_valid_out === 1'b1 && tx_ready_in === 1'b1 && tx_nodata_out === 1'b1) nd_n++;
	end
	task automatic end_of_test();
		if (fails == 0 && check_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : end_of_test
	initial begin
		#100000;
		fails++;
		end_of_test();
	end
	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask : chk
	function automatic logic [11:0] da(input logic [4:0] n, input logic [1:0] off);
		return RAM_BASE + {5'd0, n, off};
	endfunction : da
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge clk_in);
		#1;
		core_addr_in = a;
		core_wdata_in = d;
		core_we_in = 1'b1;
		@(posedge clk_in);
		#1;
		core_we_in = 1'b0;
	endtask : wr
	task automatic rd(input logic [11:0] a, output logic [7:0] d);
		@(posedge clk_in);
		#1;
		core_addr_in = a;
		core_re_in = 1'b1;
		@(posedge clk_in);
		#1;
		core_re_in = 1'b0;
		d = core_rdata_out;
	endtask : rd
	task automatic rchk(input string name, input logic [11:0] a, input logic [7:0] exp);
		logic [7:0] d;
		rd(a, d);
		chk(name, exp, d);
	endtask : rchk
	// count and address first, status byte last
	task automatic arm(input logic [4:0] n, input logic [7:0] st, input logic [7:0] cnt, input logic [15:0] ad);
		wr(da(n, OFF_CNT), cnt);
		wr(da(n, OFF_ADRL), ad[7:0]);
		wr(da(n, OFF_ADRH), ad[15:8]);
		wr(da(n, OFF_STAT), st);
	endtask : arm
	task automatic txn(input logic [3:0] pid, input logic [4:0] n, input logic en, input logic tog);
		int k;
		hs_n = 0;
		done_n = 0;
		stall_n = 0;
		last_n = 0;
		nd_n = 0;
		i_host.got_q.delete();
		i_host.token(pid, n, en, tog);
		k = 0;
		while (token_ready_out !== 1'b1 && k < 300) begin
			@(posedge clk_in);
			#1;
			k++;
		end
		if (k < 300) begin
			repeat (2) @(posedge clk_in);
			#1;
		end else begin
			fails++;
			end_of_test();
		end
	endtask : txn
	task automatic ev(input logic [7:0] n_hs, input logic [1:0] code, input logic [7:0] n_done, input logic [7:0] n_st);
		chk("hs_count", n_hs, 8'(hs_n));
		if (n_hs != 8'd0) chk("hs_code", {6'd0, code}, {6'd0, hs_last});
		chk("done_count", n_done, 8'(done_n));
		chk("stall_count", n_st, 8'(stall_n));
	endtask : ev
	initial begin
		core_addr_in = 12'h000;
		core_we_in = 1'b0;
		core_re_in = 1'b0;
		core_wdata_in = 8'h00;
		reset_in = 1'b1;
		repeat (3) @(posedge clk_in);
		#1;
		reset_in = 1'b0;
		// two bytes into the last descriptor, programmed count 256
		arm(5'd31, 8'h89, 8'h00, 16'h0280);
		i_host.packet(2, 8'hA0);
		txn(PID_OUT, 5'd31, 1'b1, 1'b0);
		ev(8'd1, HS_ACK, 8'd1, 8'd0);
		rchk("wb_status", da(5'd31, OFF_STAT), {2'b00, PID_OUT, 2'b00});
		rchk("wb_count", da(5'd31, OFF_CNT), 8'h02);
		rchk("out_byte", 12'h281, 8'hA1);
		rchk("unmapped", 12'h100, 8'h00);
		chk("trn_status", {5'd31, 3'b000}, trn_status_out);
		wr(12'h290, 8'h55);
		arm(5'd1, 8'hC8, 8'h01, 16'h0290);
		i_host.packet(1, 8'h33);
		txn(PID_OUT, 5'd1, 1'b1, 1'b0);
		ev(8'd1, HS_ACK, 8'd0, 8'd0);
		rchk("kept_status", da(5'd1, OFF_STAT), 8'hC8);
		rchk("dropped_byte", 12'h290, 8'h55);
		i_host.packet(1, 8'h33);
		txn(PID_OUT, 5'd1, 1'b1, 1'b1);
		ev(8'd1, HS_ACK, 8'd1, 8'd0);
		rchk("toggle_kept", da(5'd1, OFF_STAT), {2'b01, PID_OUT, 2'b00});
		rchk("stored_byte", 12'h290, 8'h33);
		arm(5'd2, 8'h80, 8'h01, 16'h02A0);
		i_host.packet(2, 8'h10);
		txn(PID_OUT, 5'd2, 1'b1, 1'b0);
		ev(8'd1, HS_NAK, 8'd0, 8'd0);
		rchk("nak_count", da(5'd2, OFF_CNT), 8'h01);
		i_host.word(8'h00, 1'b1, 1'b1);
		txn(PID_OUT, 5'd2, 1'b1, 1'b0);
		ev(8'd1, HS_NAK, 8'd0, 8'd0);
		rchk("err_status", da(5'd2, OFF_STAT), 8'h80);
		arm(5'd3, 8'h00, 8'h03, 16'h02B0);
		txn(PID_IN, 5'd3, 1'b1, 1'b0);
		ev(8'd1, HS_NAK, 8'd0, 8'd0);
		for (int i = 0; i < 3; i++) wr(12'h2B0 + 12'(i), 8'h70 + 8'(i));
		wr(da(5'd3, OFF_STAT), 8'h80);
		i_host.slow = 1'b1;
		txn(PID_IN, 5'd3, 1'b1, 1'b0);
		i_host.slow = 1'b0;
		ev(8'd0, HS_ACK, 8'd1, 8'd0);
		chk("in_len", 8'd3, 8'(i_host.got_q.size()));
		for (int i = 0; i < 3; i++) chk("in_byte", 8'h70 + 8'(i), i_host.got_q[i]);
		chk("in_last", 8'd1, 8'(last_n));
		chk("in_nodata", 8'd0, 8'(nd_n));
		rchk("in_status", da(5'd3, OFF_STAT), {2'b00, PID_IN, 2'b00});
		arm(5'd4, 8'h84, 8'h01, 16'h02C0);
		txn(PID_IN, 5'd4, 1'b1, 1'b0);
		ev(8'd1, HS_STALL, 8'd0, 8'd1);
		rchk("stall_status", da(5'd4, OFF_STAT), 8'h84);
		i_host.packet(1, 8'h20);
		txn(PID_SETUP, 5'd4, 1'b1, 1'b0);
		ev(8'd1, HS_ACK, 8'd0, 8'd0);
		rd(da(5'd4, OFF_STAT), rdv);
		chk("unstalled", 8'h00, rdv & 8'h84);
		arm(5'd5, 8'hC8, 8'h08, 16'h02D0);
		i_host.packet(8, 8'h60);
		txn(PID_SETUP, 5'd5, 1'b1, 1'b0);
		ev(8'd1, HS_ACK, 8'd1, 8'd0);
		rchk("setup_status", da(5'd5, OFF_STAT), {2'b01, PID_SETUP, 2'b00});
		rchk("setup_byte", 12'h2D7, 8'h67);
		// fill the receive fifo, then let a disabled endpoint drain it
		wr(12'h2E0, 8'hAA);
		arm(5'd6, 8'h80, 8'h40, 16'h02E0);
		i_host.packet(FIFO_DEPTH, 8'h00);
		@(posedge clk_in);
		#1;
		chk("fifo_full", 8'h00, {7'd0, rx_ready_out});
		txn(PID_OUT, 5'd6, 1'b0, 1'b0);
		ev(8'd0, HS_ACK, 8'd0, 8'd0);
		chk("fifo_empty", 8'h01, {7'd0, rx_ready_out});
		rchk("plain_ram", da(5'd6, OFF_STAT), 8'h80);
		rchk("plain_buf", 12'h2E0, 8'hAA);
		// zero-length packets both ways
		arm(5'd7, 8'h80, 8'h04, 16'h02F0);
		rx_nodata_in = 1'b1;
		i_host.word(8'h00, 1'b1, 1'b0);
		rx_nodata_in = 1'b0;
		txn(PID_OUT, 5'd7, 1'b1, 1'b0);
		ev(8'd1, HS_ACK, 8'd1, 8'd0);
		rchk("zlp_count", da(5'd7, OFF_CNT), 8'h00);
		arm(5'd7, 8'h80, 8'h00, 16'h02F0);
		txn(PID_IN, 5'd7, 1'b1, 1'b0);
		ev(8'd0, HS_ACK, 8'd1, 8'd0);
		chk("zlp_len", 8'd1, 8'(i_host.got_q.size()));
		chk("zlp_last", 8'd1, 8'(last_n));
		chk("zlp_nodata", 8'd1, 8'(nd_n));
		end_of_test();
	end
endmodule : ubd_table_tb_top
`default_nettype wire
